// ---- verilog/field_duty_pkg.sv ----
package field_duty_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLOCK_MHZ = 250;
   // Start delay options in milliseconds.
   localparam int unsigned START_DELAY_MS_0 = 500;
   localparam int unsigned START_DELAY_MS_1 = 2500;
   localparam int unsigned START_DELAY_MS_2 = 5000;
   localparam int unsigned START_DELAY_MS_3 = 10000;
   // Ramp-up full-scale time options in milliseconds.
   localparam int unsigned RAMP_UP_MS_0 = 2500;
   localparam int unsigned RAMP_UP_MS_1 = 3000;
   localparam int unsigned RAMP_UP_MS_2 = 5000;
   localparam int unsigned RAMP_UP_MS_3 = 6000;
   localparam int unsigned RAMP_UP_MS_4 = 7500;
   localparam int unsigned RAMP_UP_MS_5 = 9000;
   localparam int unsigned RAMP_UP_MS_6 = 10000;
   localparam int unsigned RAMP_UP_MS_7 = 12000;
   // Ramp-down time is ramp-up time times this over that.
   localparam int unsigned DOWN_NUM = 3;
   localparam int unsigned DOWN_DEN = 8;
   // Length of one millisecond tick in cycles.
   localparam int unsigned MS_CYCLES = CLOCK_MHZ * 1000;

   // ----------------------------------------------------------------
   // Duty scale: 10 bits, 1000 counts equal 100 percent (0.1 % steps)
   // ----------------------------------------------------------------
   localparam int unsigned DUTY_W = 10;
   localparam logic [DUTY_W-1:0] DUTY_FULL = 10'h3e8;
   localparam logic [DUTY_W-1:0] DUTY_ZERO = 10'h000;
   localparam logic [DUTY_W-1:0] SELF_START_DUTY = 10'h03c; // 6.0 percent.
   // Enable step options: 1.4, 6.8, 12, 24 percent.
   localparam logic [DUTY_W-1:0] STEP_0 = 10'h00e;
   localparam logic [DUTY_W-1:0] STEP_1 = 10'h044;
   localparam logic [DUTY_W-1:0] STEP_2 = 10'h078;
   localparam logic [DUTY_W-1:0] STEP_3 = 10'h0f0;
   // Blind zone options: 0, 2.3, 3.1, 4.6, 5.3, 6.2, 6.7, 8 percent.
   localparam logic [DUTY_W-1:0] BZ_0 = 10'h000;
   localparam logic [DUTY_W-1:0] BZ_1 = 10'h017;
   localparam logic [DUTY_W-1:0] BZ_2 = 10'h01f;
   localparam logic [DUTY_W-1:0] BZ_3 = 10'h02e;
   localparam logic [DUTY_W-1:0] BZ_4 = 10'h035;
   localparam logic [DUTY_W-1:0] BZ_5 = 10'h03e;
   localparam logic [DUTY_W-1:0] BZ_6 = 10'h043;
   localparam logic [DUTY_W-1:0] BZ_7 = 10'h050;

   // ----------------------------------------------------------------
   // Register map (APB, byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_LOOP   = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_SPEED  = 8'h0c;
   localparam int unsigned FREQ_W = 16;

   // Configuration fields.
   typedef struct packed {
      logic [FREQ_W-1:0] rampSpeedLimitFreq;
      logic [1:0]        loopGainSetting;
      logic              piMode;
      logic [1:0]        pStepSel;
      logic [2:0]        blindSel;
      logic [2:0]        rampUpSel;
      logic [1:0]        startDelaySel;
      logic              enable;
   } config_t;
   localparam config_t CONFIG_RESET = '{16'h0000, 2'h0, 1'b0, 2'h0, 3'h0, 3'h0, 2'h0, 1'b0};

   // Speed thresholds in phase-frequency units.
   typedef struct packed {
      logic [FREQ_W-1:0] selfStartExitSpeed;
      logic [FREQ_W-1:0] selfStartMinSpeed;
   } speed_t;
   localparam speed_t SPEED_RESET = '{16'h0000, 16'h0000};

   // Modes of the duty controller.
   typedef enum logic [1:0] {
      MODE_IDLE,
      MODE_SELF_START,
      MODE_LOOP,
      MODE_RAMP
   } mode_t;

   // APB request and answer.
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

   // Selected enable step for the current loop mode.
   function automatic logic [DUTY_W-1:0] stepOf(input logic [1:0] sel);
      case (sel)
         2'h0:    stepOf = STEP_0;
         2'h1:    stepOf = STEP_1;
         2'h2:    stepOf = STEP_2;
         default: stepOf = STEP_3;
      endcase
   endfunction : stepOf

endpackage : field_duty_pkg

// ---- verilog/tick_divider.sv ----
`timescale 1ns/1ps
// Produces a one-cycle pulse every period cycles; restart realigns it.
module tick_divider
   import field_duty_pkg::*;
(
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst,
   // Control.
   input  wire logic        restart,
   input  wire logic [31:0] period,
   // Pulse out.
   output logic             tick
);
   typedef struct packed {
      logic [31:0] count;
      logic        tick;
   } div_t;
   div_t stateQ;
   div_t stateD;

   // Counts up and fires at the end of each period.
   always_comb begin
      stateD      = stateQ;
      stateD.tick = 1'b0;
      if (restart) begin
         stateD.count = 32'h0;
      end else if (stateQ.count + 32'h1 >= period) begin
         stateD.count = 32'h0;
         stateD.tick  = 1'b1;
      end else begin
         stateD.count = stateQ.count + 32'h1;
      end
   end

   // State register.
   always_ff @(posedge clock) begin
      if (rst) begin
         stateQ <= '0;
      end else begin
         stateQ <= stateD;
      end
   end

   assign tick = stateQ.tick;
endmodule : tick_divider

// ---- verilog/phase_sync.sv ----
`timescale 1ns/1ps
// Three-stage synchroniser with agreement check and rising-edge pulse.
module phase_sync (
   // Clock and reset.
   input  wire logic clock,
   input  wire logic rst,
   // Pin in.
   input  wire logic pinIn,
   // Clean level and rising edge.
   output logic      level,
   output logic      rise
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic rise;
   } sync_t;
   sync_t stateQ;
   sync_t stateD;

   // The level changes only when stage two and three agree.
   always_comb begin
      stateD      = stateQ;
      stateD.s1   = pinIn;
      stateD.s2   = stateQ.s1;
      stateD.s3   = stateQ.s2;
      stateD.rise = 1'b0;
      if (stateQ.s2 == stateQ.s3 && stateQ.s3 != stateQ.level) begin
         stateD.level = stateQ.s3;
         stateD.rise  = stateQ.s3;
      end
   end

   // State register.
   always_ff @(posedge clock) begin
      if (rst) begin
         stateQ <= '0;
      end else begin
         stateQ <= stateD;
      end
   end

   assign level = stateQ.level;
   assign rise  = stateQ.rise;
endmodule : phase_sync

// ---- verilog/field_duty_load_response_ramp.sv ----
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Operation
// (R1) With the phase input as the only wake source, wake-up goes through self-start.
// (R2) Self-start applies the fixed duty only between the minimum and exit speeds.
// (R3) The fixed self-start duty is 6 percent.
// (R4) Above the exit speed the normal loop duty takes over.
// (R5) While the ramp runs, output current is governed only through the duty.
// (R6) The ramp can engage only after the start delay has fully elapsed.
// (R7) The ramp can engage only while phase frequency is below the speed limit.
// (R8) A rise of requested duty above the enable step triggers the ramp.
// (R9) P mode uses a selected fixed step; PI mode takes the step from the loop gain.
// (R10) The ramp starts at the previous duty plus the blind-zone offset.
// (R11) Upward ramping rises at full scale over the selected ramp-up time.
// (R12) The ramp-down time is the ramp-up time times three over eight.
// (R13) Downward ramping falls at full scale over the ramp-down time.
// (R14) A started upward ramp completes even if the speed rises above the limit.
// (R15) The start delay has four options, timed from regulation start to a done flag.
// (R16) The ramp ends when it reaches the loop duty, returning to direct loop duty.
module field_duty_load_response_ramp
   import field_duty_pkg::*;
#(
   parameter int unsigned MS_TICK = MS_CYCLES
) (
   // Clock and reset.
   input  wire logic                 clock,
   input  wire logic                 rst,
   // APB slave.
   input  field_duty_pkg::apb_req_t  apbReq,
   output field_duty_pkg::apb_rsp_t  apbRsp,
   // Wake sources and loop request.
   input  wire logic                 phaseInput,
   input  wire logic                 ignitionWake,
   input  wire logic                 lampWake,
   input  wire logic [DUTY_W-1:0]    loopDuty,
   // Field drive.
   output logic [DUTY_W-1:0]         fieldDuty,
   output logic                      selfStartWake
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      config_t           cfg;
      speed_t            spd;
      mode_t             mode;
      logic [DUTY_W-1:0] duty;
      logic [DUTY_W-1:0] prevLoop;
      logic [FREQ_W-1:0] edgeCount;
      logic [FREQ_W-1:0] phaseFreq;
      logic [15:0]       delayMs;
      logic              delayDone;
      logic              rampUp;
      logic              selfWake;
      logic [31:0]       prdata;
   } state_t;
   state_t stateQ;
   state_t stateD;

   logic              phaseLevel;
   logic              phaseRise;
   logic              msTick;
   logic              upTick;
   logic              downTick;
   logic [31:0]       upPeriod;
   logic [31:0]       downPeriod;
   logic [15:0]       rampUpMs;
   logic [15:0]       delayLimit;
   logic [DUTY_W-1:0] enableStep;
   logic [DUTY_W-1:0] blindOffset;
   logic [DUTY_W:0]   rampStart;
   logic              trigger;
   logic              triggerDown;
   logic              inWindow;
   logic              apbWr;
   logic              apbRd;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Ramp-up full-scale time for a selection, in ms.
   function automatic logic [15:0] rampMs(input logic [2:0] sel);
      case (sel)
         3'h0:    rampMs = 16'(RAMP_UP_MS_0);
         3'h1:    rampMs = 16'(RAMP_UP_MS_1);
         3'h2:    rampMs = 16'(RAMP_UP_MS_2);
         3'h3:    rampMs = 16'(RAMP_UP_MS_3);
         3'h4:    rampMs = 16'(RAMP_UP_MS_4);
         3'h5:    rampMs = 16'(RAMP_UP_MS_5);
         3'h6:    rampMs = 16'(RAMP_UP_MS_6);
         default: rampMs = 16'(RAMP_UP_MS_7);
      endcase
   endfunction : rampMs

   // Blind-zone offset for a selection.
   function automatic logic [DUTY_W-1:0] blindOf(input logic [2:0] sel);
      case (sel)
         3'h0:    blindOf = BZ_0;
         3'h1:    blindOf = BZ_1;
         3'h2:    blindOf = BZ_2;
         3'h3:    blindOf = BZ_3;
         3'h4:    blindOf = BZ_4;
         3'h5:    blindOf = BZ_5;
         3'h6:    blindOf = BZ_6;
         default: blindOf = BZ_7;
      endcase
   endfunction : blindOf

   // ----------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------
   phase_sync phaseSync (
      .clock (clock),
      .rst   (rst),
      .pinIn (phaseInput),
      .level (phaseLevel),
      .rise  (phaseRise)
   );

   tick_divider msDivider (
      .clock   (clock),
      .rst     (rst),
      .restart (1'b0),
      .period  (32'(MS_TICK)),
      .tick    (msTick)
   );

   // (R11) One duty count per ramp-up time divided by full scale.
   assign rampUpMs = rampMs(stateQ.cfg.rampUpSel);
   assign upPeriod = 32'(({16'h0, rampUpMs} * 32'(MS_TICK)) / 32'(DUTY_FULL));
   // (R12) Ramp-down time scaled by three over eight.
   assign downPeriod = 32'((upPeriod * 32'(DOWN_NUM)) / 32'(DOWN_DEN));

   tick_divider upDivider (
      .clock   (clock),
      .rst     (rst),
      .restart (stateQ.mode != MODE_RAMP),
      .period  (upPeriod),
      .tick    (upTick)
   );

   tick_divider downDivider (
      .clock   (clock),
      .rst     (rst),
      .restart (stateQ.mode != MODE_RAMP),
      .period  (downPeriod),
      .tick    (downTick)
   );

   // ----------------------------------------------------------------
   // Ramp decisions
   // ----------------------------------------------------------------
   // (R15) Start delay option limit.
   always_comb begin
      case (stateQ.cfg.startDelaySel)
         2'h0:    delayLimit = 16'(START_DELAY_MS_0);
         2'h1:    delayLimit = 16'(START_DELAY_MS_1);
         2'h2:    delayLimit = 16'(START_DELAY_MS_2);
         default: delayLimit = 16'(START_DELAY_MS_3);
      endcase
   end

   // (R9) Enable step by loop mode.
   assign enableStep  = stateQ.cfg.piMode ? stepOf(stateQ.cfg.loopGainSetting)
                                          : stepOf(stateQ.cfg.pStepSel);
   assign blindOffset = blindOf(stateQ.cfg.blindSel);
   // (R10) Start point with saturation at full scale.
   assign rampStart   = {1'b0, stateQ.prevLoop} + {1'b0, blindOffset};
   // (R6) (R7) (R8) Trigger gated by delay, speed and step size.
   assign trigger = stateQ.delayDone
                    && (stateQ.phaseFreq < stateQ.cfg.rampSpeedLimitFreq)
                    && (loopDuty > stateQ.prevLoop)
                    && ((loopDuty - stateQ.prevLoop) > enableStep);
   // (R13) A fall of the request beyond the step ramps down under the same gating.
   assign triggerDown = stateQ.delayDone
                        && (stateQ.phaseFreq < stateQ.cfg.rampSpeedLimitFreq)
                        && (stateQ.prevLoop > loopDuty)
                        && ((stateQ.prevLoop - loopDuty) > enableStep);
   // (R2) Speed window for self-start.
   assign inWindow = (stateQ.phaseFreq > stateQ.spd.selfStartMinSpeed)
                     && (stateQ.phaseFreq < stateQ.spd.selfStartExitSpeed);

   assign apbWr = apbReq.psel && apbReq.penable && apbReq.pwrite;
   assign apbRd = apbReq.psel && !apbReq.penable && !apbReq.pwrite;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      stateD = stateQ;
      // Phase frequency: rising edges counted over each millisecond window.
      if (msTick) begin
         stateD.phaseFreq = stateQ.edgeCount;
         stateD.edgeCount = FREQ_W'(phaseRise);
      end else if (phaseRise && stateQ.edgeCount != '1) begin
         stateD.edgeCount = stateQ.edgeCount + FREQ_W'(1);
      end
      // (R15) Delay counter from regulation start.
      if (stateQ.mode != MODE_LOOP && stateQ.mode != MODE_RAMP) begin
         stateD.delayMs   = 16'h0;
         stateD.delayDone = 1'b0;
      end else if (msTick && !stateQ.delayDone) begin
         stateD.delayMs = stateQ.delayMs + 16'h1;
         if (stateQ.delayMs + 16'h1 >= delayLimit) begin
            stateD.delayDone = 1'b1;
         end
      end
      case (stateQ.mode)
         MODE_IDLE: begin
            stateD.duty = DUTY_ZERO;
            if (stateQ.cfg.enable) begin
               // (R1) Phase-only wake takes the self-start path.
               if (!ignitionWake && !lampWake && phaseLevel) begin
                  stateD.mode     = MODE_SELF_START;
                  stateD.selfWake = 1'b1;
               end else if (ignitionWake || lampWake) begin
                  stateD.mode = MODE_LOOP;
               end
            end
         end
         MODE_SELF_START: begin
            // (R2) (R3) Fixed duty only inside the speed window.
            stateD.duty = inWindow ? SELF_START_DUTY : DUTY_ZERO;
            // (R4) Hand over to the loop above the exit speed.
            if (stateQ.phaseFreq >= stateQ.spd.selfStartExitSpeed) begin
               stateD.mode     = MODE_LOOP;
               stateD.prevLoop = loopDuty;
            end
         end
         MODE_LOOP: begin
            if (trigger) begin
               stateD.mode     = MODE_RAMP;
               stateD.rampUp   = 1'b1;
               stateD.duty     = rampStart > {1'b0, DUTY_FULL} ? DUTY_FULL
                                                              : rampStart[DUTY_W-1:0];
            end else if (triggerDown) begin
               // (R13) Hold the previous duty and let the down slope carry it.
               stateD.mode   = MODE_RAMP;
               stateD.rampUp = 1'b0;
               stateD.duty   = stateQ.prevLoop;
            end else begin
               stateD.duty = loopDuty;
            end
            stateD.prevLoop = loopDuty;
         end
         MODE_RAMP: begin
            // (R5) (R14) Ramp owns the duty regardless of speed until done.
            stateD.rampUp = loopDuty > stateQ.duty;
            if (stateQ.rampUp && stateQ.duty >= loopDuty) begin
               // (R16) Reached the request: back to direct loop duty.
               stateD.mode = MODE_LOOP;
               stateD.duty = loopDuty;
            end else if (!stateQ.rampUp && stateQ.duty <= loopDuty) begin
               stateD.mode = MODE_LOOP;
               stateD.duty = loopDuty;
            end else if (stateQ.rampUp && upTick) begin
               // (R11) Constant upward slope.
               stateD.duty = stateQ.duty + DUTY_W'(1);
            end else if (!stateQ.rampUp && downTick) begin
               // (R13) Constant downward slope.
               stateD.duty = stateQ.duty - DUTY_W'(1);
            end
            stateD.prevLoop = loopDuty;
         end
         default: stateD.mode = MODE_IDLE;
      endcase
      if (!stateQ.cfg.enable) begin
         stateD.mode     = MODE_IDLE;
         stateD.selfWake = 1'b0;
      end
      // APB register writes.
      if (apbWr) begin
         case (apbReq.paddr)
            ADDR_CONFIG: stateD.cfg = config_t'(apbReq.pwdata[$bits(config_t)-1:0]);
            ADDR_SPEED:  stateD.spd = speed_t'(apbReq.pwdata);
            default:     stateD.prdata = stateQ.prdata;
         endcase
      end
      // APB read data captured in the setup cycle.
      if (apbRd) begin
         case (apbReq.paddr)
            ADDR_CONFIG: stateD.prdata = 32'(stateQ.cfg);
            ADDR_LOOP:   stateD.prdata = {6'h0, loopDuty, 6'h0, stateQ.duty};
            ADDR_STATUS: stateD.prdata = {stateQ.phaseFreq, 10'h0, stateQ.selfWake,
                                          stateQ.rampUp, stateQ.delayDone, 1'b0,
                                          2'(stateQ.mode)};
            ADDR_SPEED:  stateD.prdata = 32'(stateQ.spd);
            default:     stateD.prdata = 32'h0;
         endcase
      end
   end

   // State register.
   always_ff @(posedge clock) begin
      if (rst) begin
         stateQ <= '{cfg: CONFIG_RESET, spd: SPEED_RESET, mode: MODE_IDLE, default: '0};
      end else begin
         stateQ <= stateD;
      end
   end

   // Outputs.
   assign fieldDuty      = stateQ.duty;
   assign selfStartWake  = stateQ.selfWake;
   assign apbRsp.pready  = 1'b1;
   assign apbRsp.pslverr = apbReq.psel && apbReq.penable
                           && (apbReq.paddr[1:0] != 2'h0 || apbReq.paddr > ADDR_SPEED);
   assign apbRsp.prdata  = stateQ.prdata;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_ramp_needs_delay: assert property (@(posedge clock) disable iff (rst) // (R6)
      (stateQ.mode == MODE_LOOP && stateD.mode == MODE_RAMP) |-> stateQ.delayDone)
      else $error("ramp engaged before start delay");
   chk_ramp_low_speed: assert property (@(posedge clock) disable iff (rst) // (R7)
      (stateQ.mode == MODE_LOOP && stateD.mode == MODE_RAMP)
      |-> stateQ.phaseFreq < stateQ.cfg.rampSpeedLimitFreq)
      else $error("ramp engaged at high speed");
   chk_ramp_step_size: assert property (@(posedge clock) disable iff (rst) // (R8)
      (stateQ.mode == MODE_LOOP && stateD.mode == MODE_RAMP && stateD.rampUp)
      |-> (loopDuty - stateQ.prevLoop) > enableStep)
      else $error("ramp triggered below step");
   chk_ramp_start_point: assert property (@(posedge clock) disable iff (rst) // (R10)
      (stateQ.mode == MODE_LOOP && trigger && stateQ.cfg.enable && rampStart <= 11'(DUTY_FULL))
      |=> fieldDuty == $past(rampStart[DUTY_W-1:0]))
      else $error("ramp start point wrong");
   chk_self_start_duty: assert property (@(posedge clock) disable iff (rst) // (R3)
      (stateQ.mode == MODE_SELF_START && inWindow && stateD.mode == MODE_SELF_START)
      |=> fieldDuty == SELF_START_DUTY)
      else $error("self-start duty wrong");
   chk_self_start_window: assert property (@(posedge clock) disable iff (rst) // (R2)
      (stateQ.mode == MODE_SELF_START && fieldDuty != DUTY_ZERO) |-> $past(inWindow))
      else $error("self-start duty outside window");
   chk_self_start_exit: assert property (@(posedge clock) disable iff (rst) // (R4)
      (stateQ.mode == MODE_SELF_START && stateQ.cfg.enable
       && stateQ.phaseFreq >= stateQ.spd.selfStartExitSpeed) |=> stateQ.mode == MODE_LOOP)
      else $error("self-start did not exit");
   chk_phase_only_wake: assert property (@(posedge clock) disable iff (rst) // (R1)
      (stateQ.mode == MODE_IDLE && stateD.mode == MODE_SELF_START)
      |-> !ignitionWake && !lampWake)
      else $error("self-start with other wake source");
   chk_ramp_step_one: assert property (@(posedge clock) disable iff (rst) // (R11)
      (stateQ.mode == MODE_RAMP && $past(stateQ.mode) == MODE_RAMP && stateQ.rampUp
       && stateD.mode == MODE_RAMP) |-> stateD.duty - stateQ.duty <= DUTY_W'(1))
      else $error("ramp slope too steep");
   chk_ramp_end: assert property (@(posedge clock) disable iff (rst) // (R16)
      (stateQ.mode == MODE_RAMP && stateQ.rampUp && stateQ.duty >= loopDuty
       && stateQ.cfg.enable) |=> stateQ.mode == MODE_LOOP)
      else $error("ramp did not end");

   cov_self_start: cover property (@(posedge clock) disable iff (rst)
      stateQ.mode == MODE_SELF_START ##1 stateQ.mode == MODE_LOOP);
   cov_ramp_up: cover property (@(posedge clock) disable iff (rst)
      stateQ.mode == MODE_RAMP && stateQ.rampUp ##1 stateQ.mode == MODE_LOOP);
   cov_ramp_down: cover property (@(posedge clock) disable iff (rst)
      stateQ.mode == MODE_RAMP && !stateQ.rampUp);
endmodule : field_duty_load_response_ramp

// ---- verification/field_winding_model.sv ----
`timescale 1ns/1ps
// Alternator side: makes the phase signal at a set half period; 0 stops the rotor.
module field_winding_model (
   // Clock and reset.
   input  wire logic       clock,
   input  wire logic       rst,
   // Rotor speed.
   input  wire logic [7:0] halfPeriod,
   // Phase pin.
   output logic            phaseInput
);
   logic [7:0] count;
   // Toggles the phase pin each half period; it stands low when the rotor stops.
   always_ff @(posedge clock) begin
      if (rst || halfPeriod == 8'h00) begin
         count      <= 8'h00;
         phaseInput <= 1'b0;
      end else if (count + 8'h01 >= halfPeriod) begin
         count      <= 8'h00;
         phaseInput <= ~phaseInput;
      end else begin
         count <= count + 8'h01;
      end
   end
endmodule : field_winding_model

// ---- verification/field_duty_load_response_ramp_tb.sv ----
`timescale 1ns/1ps
module field_duty_load_response_ramp_tb;
   import field_duty_pkg::*;
   logic              clock = 1'b0;
   logic              rst = 1'b1;
   apb_req_t          apbReq = '0;
   apb_rsp_t          apbRsp;
   logic [DUTY_W-1:0] loopDuty = 10'h064;
   logic [DUTY_W-1:0] fieldDuty;
   logic              phaseInput;
   logic              selfStartWake;
   logic [7:0]        halfPeriod = 8'h00;
   logic              ignitionWake = 1'b0;
   logic              lampWake = 1'b0;
   logic [31:0]       rd;
   logic              err;
   int                num_errors = 0;
   int                samples_checked = 0;
   int                cycles = 0;
   always #2 clock = ~clock;
   field_duty_load_response_ramp #(.MS_TICK(40)) field_duty_load_response_ramp_i (
      .clock(clock), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp), .phaseInput(phaseInput),
      .ignitionWake(ignitionWake), .lampWake(lampWake), .loopDuty(loopDuty),
      .fieldDuty(fieldDuty), .selfStartWake(selfStartWake));
   field_winding_model field_winding_model_i (.clock(clock), .rst(rst),
      .halfPeriod(halfPeriod), .phaseInput(phaseInput));
   task automatic final_report();
      if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer, entered just after a rising edge.
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      apbReq <= '{1'b1, 1'b0, wr, addr, wd};
      @(posedge clock);
      apbReq.penable <= 1'b1;
      @(posedge clock);
      while (apbRsp.pready !== 1'b1) @(posedge clock);
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq <= '0;
      @(posedge clock);
   endtask : apb
   task automatic waitDuty(input logic [9:0] v, input int n);
      repeat (n) if (fieldDuty !== v) @(posedge clock);
   endtask : waitDuty
   // Cuts a hang short.
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         num_errors++;
         final_report();
      end
   end
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      chk(fieldDuty, 32'h0);
      apb(1'b0, ADDR_CONFIG, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk(err, 32'h1);
      apb(1'b1, ADDR_SPEED, 32'h00040001);
      halfPeriod <= 8'h0a;
      ignitionWake <= 1'b1;
      lampWake <= 1'b1;
      apb(1'b1, ADDR_CONFIG, 32'h000281c1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[5:0], 32'h02);
      apb(1'b1, ADDR_CONFIG, 32'h000281c0);
      ignitionWake <= 1'b0;
      lampWake <= 1'b0;
      apb(1'b1, ADDR_CONFIG, 32'h000281c1);
      repeat (200) @(posedge clock);
      chk(fieldDuty, SELF_START_DUTY);
      chk(selfStartWake, 32'h1);
      halfPeriod <= 8'h04;
      repeat (200) @(posedge clock);
      chk(fieldDuty, 32'h64);
      loopDuty <= 10'h0c8;
      repeat (5) @(posedge clock);
      chk(fieldDuty, 32'hc8);
      loopDuty <= 10'h064;
      repeat (21000) @(posedge clock);
      loopDuty <= 10'h0c8;
      repeat (5) @(posedge clock);
      chk(fieldDuty, 32'hb4);
      waitDuty(10'h0b5, 200);
      repeat (1050) @(posedge clock);
      chk(fieldDuty, 32'hbf);
      apb(1'b1, ADDR_CONFIG, 32'h000001c1);
      waitDuty(10'h0c8, 1500);
      chk(fieldDuty, 32'hc8);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[1:0], 32'h2);
      loopDuty <= 10'h12c;
      repeat (5) @(posedge clock);
      chk(fieldDuty, 32'h12c);
      apb(1'b1, ADDR_CONFIG, 32'h0002b9c1);
      loopDuty <= 10'h1f4;
      repeat (5) @(posedge clock);
      chk(fieldDuty, 32'h1f4);
      loopDuty <= 10'h320;
      repeat (5) @(posedge clock);
      chk(fieldDuty, 32'h244);
      loopDuty <= 10'h23a;
      waitDuty(10'h23a, 600);
      chk(fieldDuty, 32'h23a);
      loopDuty <= 10'h13a;
      repeat (5) @(posedge clock);
      chk(fieldDuty, 32'h23a);
      repeat (395) @(posedge clock);
      chk(fieldDuty, 32'h230);
      final_report();
   end
endmodule : field_duty_load_response_ramp_tb
